// >>> rtl/cps_pkg.sv
// constants, types and timing counts for the configuration port sequencer
// Operation
// - load and enable I/O within 53/25/13 ms
// - I/O active 49 config clocks after done
// - master waits 1200 us before first clock
// - master clock low, medium or high rate
// - readback launched on falling slave clock edge
package cps_pkg;
	////////////////////////////////////////////////////////////////////////////
	// system clock
	localparam int CLK_KHZ          = 125000;          // clk_in rate
	// memory clear wait after reset release
	localparam int T_CLEAR_US       = 1200;            // least wait, microseconds
	localparam int CLEAR_CYC        = (T_CLEAR_US * CLK_KHZ + 999) / 1000;
	// total load budget per rate setting, longest times round down
	localparam int T_LOAD_LOW_MS    = 53;
	localparam int T_LOAD_MED_MS    = 25;
	localparam int T_LOAD_HIGH_MS   = 13;
	localparam int LOAD_LOW_CYC     = T_LOAD_LOW_MS * CLK_KHZ;
	localparam int LOAD_MED_CYC     = T_LOAD_MED_MS * CLK_KHZ;
	localparam int LOAD_HIGH_CYC    = T_LOAD_HIGH_MS * CLK_KHZ;
	// nominal master clock rates and half periods in clk_in cycles
	localparam int MCLK_LOW_KHZ     = 12000;
	localparam int MCLK_MED_KHZ     = 33000;
	localparam int MCLK_HIGH_KHZ    = 53000;
	localparam logic [3:0] HALF_LOW  = 4'((CLK_KHZ + MCLK_LOW_KHZ) / (2 * MCLK_LOW_KHZ));
	localparam logic [3:0] HALF_MED  = 4'((CLK_KHZ + MCLK_MED_KHZ) / (2 * MCLK_MED_KHZ));
	localparam logic [3:0] HALF_HIGH = 4'((CLK_KHZ + MCLK_HIGH_KHZ) / (2 * MCLK_HIGH_KHZ));
	// configuration clocks between done and I/O activation
	localparam logic [5:0] DONE_IO_CYC = 6'd49;
	// readback output valid after falling slave clock edge, nanoseconds
	localparam int T_STCO_NS        = 13;
	////////////////////////////////////////////////////////////////////////////
	// data path
	localparam int BYTE_W           = 8;               // fifo word width
	localparam int FIFO_DEPTH       = 4;               // fifo words
	localparam int OTM_AW           = 16;              // one-time memory address width
	localparam logic [31:0] FLASH_READ_CMD = 32'h0300_0000; // read opcode, address zero
	localparam logic [5:0]  CMD_BITS       = 6'h20;         // command bits sent first
	// readback status byte bit positions
	localparam int STAT_DONE        = 7;
	localparam int STAT_IO          = 6;
	localparam int STAT_ERR         = 5;
	////////////////////////////////////////////////////////////////////////////
	// configuration source strap
	typedef enum logic [1:0] {
		cps_src_otm,        // internal one-time memory
		cps_src_master,     // external flash, device drives clock
		cps_src_slave,      // host writes, host drives clock
		cps_src_rsvd
	} cps_src_t;
	// master clock rate strap
	typedef enum logic [1:0] {
		cps_rate_low,       // default
		cps_rate_med,
		cps_rate_high,
		cps_rate_rsvd
	} cps_rate_t;
endpackage

// >>> rtl/cps_fifo.sv
// small word fifo with registered output stage
`timescale 1ns/1ns
module cps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	// filling side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// draining side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];       // storage
	logic [AW-1:0]    wr_ptr;            // write slot
	logic [AW-1:0]    rd_ptr;            // read slot
	logic [AW:0]      count;             // words held in storage
	logic             push;              // word taken in
	logic             pop;               // word moved to output stage
	////////////////////////////////////////////////////////////////////////////
	// handshakes; the output stage is not a slot
	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign push = in_valid_in && in_ready_out;
	assign pop  = (count != '0) && (!out_valid_out || out_ready_in);
	// storage write
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	// pointers and fill level
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
			end
			if (pop) begin
				rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// output register, consumer sees flip-flops
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out  <= mem[rd_ptr];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule

// >>> rtl/cps_config_port_sequencer.sv
// configuration port sequencer: reset, clear wait, load from three sources, I/O release
`timescale 1ns/1ns
module cps_config_port_sequencer
	import cps_pkg::*;
#(
	parameter int CLEAR_CYCLES     = cps_pkg::CLEAR_CYC,
	parameter int LOAD_LOW_CYCLES  = cps_pkg::LOAD_LOW_CYC,
	parameter int LOAD_MED_CYCLES  = cps_pkg::LOAD_MED_CYC,
	parameter int LOAD_HIGH_CYCLES = cps_pkg::LOAD_HIGH_CYC
) (
	// system clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       sys_rst_in,
	// configuration pins and straps
	input  wire logic                       config_reset_n_in,
	input  wire logic [1:0]                 cfg_source_in,
	input  wire logic [1:0]                 cfg_rate_in,
	output logic                            config_done_flag_out,
	output logic                            user_io_enable_out,
	output logic                            config_error_out,
	// master spi to external flash
	output logic                            mspi_clk_out,
	output logic                            mspi_cs_n_out,
	output logic                            mspi_mosi_out,
	input  wire logic                       mspi_miso_in,
	// slave spi from host, on its own clock
	input  wire logic                       slave_config_clock,
	input  wire logic                       slave_cs_n_in,
	input  wire logic                       slave_mosi_in,
	output logic                            slave_miso_out,
	output logic                            slave_miso_oe_out,
	// one-time configuration memory read port
	output logic                            otm_rd_req_out,
	output logic [cps_pkg::OTM_AW-1:0]      otm_rd_addr_out,
	input  wire logic                       otm_rd_valid_in,
	input  wire logic [cps_pkg::BYTE_W-1:0] otm_rd_data_in,
	// bitstream bytes to the configuration array
	output logic                            cfg_wr_valid_out,
	output logic [cps_pkg::BYTE_W-1:0]      cfg_wr_data_out,
	input  wire logic                       cfg_wr_ready_in,
	input  wire logic                       cfg_load_ok_in
);
	import cps_pkg::*;

	typedef enum logic [2:0] {
		cps_st_reset,       // reset pin held low
		cps_st_clear,       // clearing configuration memory
		cps_st_load,        // bitstream flowing
		cps_st_io_wait,     // done high, counting clocks
		cps_st_active,      // user I/O running
		cps_st_fail         // budget blown or data lost
	} cps_state_t;

	cps_state_t      state;             // sequencer state
	logic [1:0]      rst_pin_sync;      // reset pin synchroniser
	logic [1:0]      src_sync [2];      // source strap synchroniser
	logic [1:0]      rate_sync [2];     // rate strap synchroniser
	logic            miso_meta;         // flash data, first stage
	logic            miso_s;            // flash data, usable
	cps_src_t        source;            // strap caught at reset release
	cps_rate_t       rate;              // strap caught at reset release
	logic [22:0]     clear_cnt;         // clear wait counter
	logic [22:0]     load_cnt;          // load budget counter
	logic [22:0]     load_budget;       // budget for the chosen rate
	logic [3:0]      half_cyc;          // master clock half period
	logic [3:0]      div_cnt;           // master clock divider
	logic            tick;              // half period elapsed
	logic            clk_run;           // configuration clock running
	logic            stall;             // fifo cannot take the next byte
	logic            mclk_rise;         // rising edge this cycle
	logic            mclk_fall;         // falling edge this cycle
	logic [31:0]     cmd_sr;            // command shifter
	logic [5:0]      cmd_cnt;           // command bits sent
	logic [2:0]      bit_cnt;           // data bits in current byte
	logic [6:0]      byte_sr;           // partial flash byte
	logic            otm_pending;       // one-time memory read in flight
	logic [5:0]      io_cnt;            // configuration clocks after done
	logic            fifo_valid;        // byte offered to fifo
	logic [7:0]      fifo_data;         // byte offered to fifo
	logic            fifo_ready;        // fifo has room
	logic            lost_byte;         // slave byte found no room
	// link domain
	logic [1:0]      lnk_rst_sync;      // reset into link domain
	logic [2:0]      lnk_lvl_meta;      // done, io, error first stage
	logic [2:0]      lnk_lvl;           // done, io, error usable
	logic [2:0]      lnk_bits;          // bits in current slave byte
	logic [6:0]      lnk_sr;            // partial slave byte
	logic [7:0]      lnk_byte;          // completed slave byte, held
	logic            lnk_tog;           // toggles per completed byte
	logic [5:0]      lnk_io_cnt;        // slave clocks after done
	logic            lnk_io_ok;         // enough slave clocks seen
	logic [7:0]      lnk_rb_sr;         // readback shifter
	// link to system crossing
	logic [2:0]      tog_sync;          // byte toggle, two stages and history
	logic [1:0]      io_ok_sync;        // slave clock count reached

	function automatic logic in_cfg_clock(input cps_state_t st);
		in_cfg_clock = (st == cps_st_load) || (st == cps_st_io_wait);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clk_in) begin
		rst_pin_sync <= {rst_pin_sync[0], config_reset_n_in};
		src_sync[0]  <= cfg_source_in;
		src_sync[1]  <= src_sync[0];
		rate_sync[0] <= cfg_rate_in;
		rate_sync[1] <= rate_sync[0];
		miso_meta    <= mspi_miso_in;
		miso_s       <= miso_meta;
	end

	// straps caught while the pin is low, held for the whole load
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			source <= cps_src_otm;
			rate   <= cps_rate_low;
		end else if (state == cps_st_reset) begin
			source <= cps_src_t'(src_sync[1]);
			rate   <= (rate_sync[1] == cps_rate_rsvd) ? cps_rate_low : cps_rate_t'(rate_sync[1]);
		end
	end

	// rate setting picks clock half period and load budget
	always_comb begin
		unique case (rate)
			cps_rate_med: begin
				half_cyc    = HALF_MED;
				load_budget = 23'(LOAD_MED_CYCLES);
			end
			cps_rate_high: begin
				half_cyc    = HALF_HIGH;
				load_budget = 23'(LOAD_HIGH_CYCLES);
			end
			default: begin
				half_cyc    = HALF_LOW;
				load_budget = 23'(LOAD_LOW_CYCLES);
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer; a low reset pin restarts from any state
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= cps_st_reset;
		end else if (!rst_pin_sync[1]) begin
			state <= cps_st_reset;
		end else begin
			unique case (state)
				cps_st_reset: begin
					state <= cps_st_clear;
				end
				cps_st_clear: begin
					// no clock and no accepted byte until memory is cleared
					if (clear_cnt == 23'(CLEAR_CYCLES - 1)) begin
						state <= cps_st_load;
					end
				end
				cps_st_load: begin
					if (lost_byte || load_cnt == load_budget) begin
						state <= cps_st_fail;
					end else if (cfg_load_ok_in) begin
						state <= cps_st_io_wait;
					end
				end
				cps_st_io_wait: begin
					if (load_cnt == load_budget) begin
						state <= cps_st_fail;
					end else if (io_cnt == DONE_IO_CYC || io_ok_sync[1]) begin
						state <= cps_st_active;
					end
				end
				cps_st_active: begin
					state <= cps_st_active;
				end
				cps_st_fail: begin
					state <= cps_st_fail;
				end
			endcase
		end
	end

	// clear wait and load budget, both measured from reset release
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || state == cps_st_reset) begin
			clear_cnt <= '0;
			load_cnt  <= '0;
		end else begin
			if (state == cps_st_clear) begin
				clear_cnt <= clear_cnt + 23'h1;
			end
			if (state != cps_st_active && state != cps_st_fail) begin
				load_cnt <= load_cnt + 23'h1;
			end
		end
	end

	// status pins
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			config_done_flag_out <= 1'b0;
			user_io_enable_out   <= 1'b0;
			config_error_out     <= 1'b0;
		end else begin
			config_done_flag_out <= (state == cps_st_io_wait) || (state == cps_st_active);
			user_io_enable_out   <= (state == cps_st_active);
			config_error_out     <= (state == cps_st_fail);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration clock; also runs for the one-time memory so done can count it
	assign clk_run   = in_cfg_clock(state) && source != cps_src_slave;
	assign tick      = clk_run && (div_cnt == half_cyc - 4'h1);
	// the last bit of a byte waits for room, so back-pressure stops the flash
	assign stall     = state == cps_st_load && source == cps_src_master
	                   && cmd_cnt == CMD_BITS && bit_cnt == 3'h7 && !fifo_ready;
	assign mclk_rise = tick && !mspi_clk_out && !stall;
	assign mclk_fall = tick && mspi_clk_out;

	// divider and clock pin
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !clk_run) begin
			div_cnt      <= '0;
			mspi_clk_out <= 1'b0;
		end else begin
			div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
			if (mclk_rise || mclk_fall) begin
				mspi_clk_out <= mclk_rise;
			end
		end
	end

	// flash command out on falling edges, data in on rising edges
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || state != cps_st_load || source != cps_src_master) begin
			mspi_cs_n_out <= 1'b1;
			cmd_sr        <= FLASH_READ_CMD;
			mspi_mosi_out <= 1'b0;
			cmd_cnt       <= '0;
			bit_cnt       <= '0;
			byte_sr       <= '0;
		end else begin
			mspi_cs_n_out <= 1'b0;
			mspi_mosi_out <= cmd_sr[31];
			if (mclk_fall) begin
				cmd_sr <= {cmd_sr[30:0], 1'b0};
			end
			if (mclk_rise && cmd_cnt != CMD_BITS) begin
				cmd_cnt <= cmd_cnt + 6'h1;
			end else if (mclk_rise) begin
				bit_cnt <= bit_cnt + 3'h1;
				byte_sr <= {byte_sr[5:0], miso_s};
			end
		end
	end

	// one-time memory reads, one in flight, issued only with room in the fifo
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || state != cps_st_load || source != cps_src_otm) begin
			otm_rd_req_out  <= 1'b0;
			otm_rd_addr_out <= '0;
			otm_pending     <= 1'b0;
		end else begin
			otm_rd_req_out <= !otm_pending && !otm_rd_req_out && fifo_ready;
			if (otm_rd_req_out) begin
				otm_pending <= 1'b1;
			end else if (otm_rd_valid_in) begin
				otm_pending     <= 1'b0;
				otm_rd_addr_out <= otm_rd_addr_out + 16'h1;
			end
		end
	end

	// configuration clocks counted after done for the one-time memory and flash sources
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || state != cps_st_io_wait) begin
			io_cnt <= '0;
		end else if (mclk_rise && io_cnt != DONE_IO_CYC) begin
			io_cnt <= io_cnt + 6'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// byte toggle and clock count from the link domain
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tog_sync   <= '0;
			io_ok_sync <= '0;
		end else begin
			tog_sync   <= {tog_sync[1:0], lnk_tog};
			io_ok_sync <= {io_ok_sync[0], lnk_io_ok && source == cps_src_slave};
		end
	end

	// one source feeds the fifo; lnk_byte holds eight slave clocks
	always_comb begin
		fifo_valid = 1'b0;
		fifo_data  = '0;
		lost_byte  = 1'b0;
		if (state == cps_st_load) begin
			unique case (source)
				cps_src_master: begin
					fifo_valid = mclk_rise && cmd_cnt == CMD_BITS && bit_cnt == 3'h7;
					fifo_data  = {byte_sr, miso_s};
				end
				cps_src_slave: begin
					fifo_valid = tog_sync[2] ^ tog_sync[1];
					fifo_data  = lnk_byte;
					lost_byte  = fifo_valid && !fifo_ready; // host cannot be stalled
				end
				default: begin
					fifo_valid = otm_pending && otm_rd_valid_in;
					fifo_data  = otm_rd_data_in;
				end
			endcase
		end
	end

	cps_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (fifo_valid),
		.in_data_in    (fifo_data),
		.in_ready_out  (fifo_ready),
		.out_valid_out (cfg_wr_valid_out),
		.out_data_out  (cfg_wr_data_out),
		.out_ready_in  (cfg_wr_ready_in)
	);

	////////////////////////////////////////////////////////////////////////////
	// link domain reset and status levels
	always_ff @(posedge slave_config_clock) begin
		lnk_rst_sync <= {lnk_rst_sync[0], sys_rst_in || !config_reset_n_in};
		lnk_lvl_meta <= {config_done_flag_out, user_io_enable_out, config_error_out};
		lnk_lvl      <= lnk_lvl_meta;
	end

	// slave write bytes, msb first on rising edges
	always_ff @(posedge slave_config_clock) begin
		if (lnk_rst_sync[1]) begin
			lnk_bits <= '0;
			lnk_sr   <= '0;
			lnk_byte <= '0;
			lnk_tog  <= 1'b0;
		end else if (!slave_cs_n_in) begin
			lnk_bits <= lnk_bits + 3'h1;
			lnk_sr   <= {lnk_sr[5:0], slave_mosi_in};
			if (lnk_bits == 3'h7) begin
				lnk_byte <= {lnk_sr, slave_mosi_in};
				lnk_tog  <= ~lnk_tog;
			end
		end else begin
			lnk_bits <= '0;
		end
	end

	// host clocks after done counted here
	always_ff @(posedge slave_config_clock) begin
		if (lnk_rst_sync[1] || !lnk_lvl[2]) begin
			lnk_io_cnt <= '0;
			lnk_io_ok  <= 1'b0;
		end else if (lnk_io_cnt != DONE_IO_CYC) begin
			lnk_io_cnt <= lnk_io_cnt + 6'h1;
		end else begin
			lnk_io_ok <= 1'b1;
		end
	end

	// readback status byte, launched on falling edges
	always_ff @(negedge slave_config_clock) begin
		if (lnk_rst_sync[1] || slave_cs_n_in) begin
			lnk_rb_sr         <= {lnk_lvl[2], lnk_lvl[1], lnk_lvl[0], 5'h00};
			slave_miso_out    <= 1'b0;
			slave_miso_oe_out <= 1'b0;
		end else begin
			slave_miso_out    <= lnk_rb_sr[STAT_DONE];
			lnk_rb_sr         <= {lnk_rb_sr[6:0], 1'b0};
			slave_miso_oe_out <= 1'b1;
		end
	end
endmodule

// >>> bench/cps_monitor.sv
// assertion checker bound to the sequencer's ports
`timescale 1ns/1ns
module cps_monitor #(
	parameter int CLEAR_CYCLES     = 20,
	parameter int LOAD_LOW_CYCLES  = 3000,
	parameter int LOAD_MED_CYCLES  = 2000,
	parameter int LOAD_HIGH_CYCLES = 1500
) (
	// clock, reset, pin and straps
	input wire logic       clk_in,
	input wire logic       sys_rst_in,
	input wire logic       config_reset_n_in,
	input wire logic [1:0] cfg_source_in,
	input wire logic [1:0] cfg_rate_in,
	// status and master bus
	input wire logic       config_done_flag_out,
	input wire logic       user_io_enable_out,
	input wire logic       config_error_out,
	input wire logic       mspi_clk_out,
	input wire logic       mspi_cs_n_out,
	// read port and array side
	input wire logic       otm_rd_req_out,
	input wire logic       cfg_wr_valid_out,
	input wire logic [7:0] cfg_wr_data_out,
	input wire logic       cfg_wr_ready_in
);
	////////////////////////////////////////////////////////////////////////////
	logic [31:0] rel_cnt; // cycles since the raw pin rose
	logic [7:0]  mrise;   // clock rises while done is high
	logic        mclk_q;  // last master clock level
	int          budget;  // load budget of the strapped rate
	// raw pin leads the synced one
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !config_reset_n_in) rel_cnt <= 32'h0;
		else if (rel_cnt != 32'hffffffff) rel_cnt <= rel_cnt + 32'h1;
	end
	always_ff @(posedge clk_in) mclk_q <= mspi_clk_out;
	always_ff @(posedge clk_in) begin
		if (!config_done_flag_out) mrise <= 8'h0;
		else if (mspi_clk_out && !mclk_q && mrise != 8'hff) mrise <= mrise + 8'h1;
	end
	always_comb budget = (cfg_rate_in == 2'h1) ? LOAD_MED_CYCLES :
		(cfg_rate_in == 2'h2) ? LOAD_HIGH_CYCLES : LOAD_LOW_CYCLES;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////////
	chk_clear_wait: assert property (
		$rose(mspi_clk_out) |-> rel_cnt >= CLEAR_CYCLES) else $error("clock before clear wait");
	chk_io_budget: assert property (
		$rose(user_io_enable_out) |-> rel_cnt <= budget + 8) else $error("io late");
	chk_budget_fail: assert property (
		rel_cnt == budget + 8 && !user_io_enable_out && config_reset_n_in |-> config_error_out)
		else $error("no error after budget");
	// done lags io_wait entry by a cycle
	chk_done_io_gap: assert property (
		$rose(user_io_enable_out) && cfg_source_in != 2'h2 |-> mrise >= 8'd48)
		else $error("io too soon after done");
	chk_io_needs_done: assert property (
		user_io_enable_out |-> config_done_flag_out) else $error("io without done");
	chk_done_restart: assert property (
		!config_reset_n_in [*6] |-> !config_done_flag_out && !user_io_enable_out)
		else $error("done held in restart");
	chk_mclk_low_rate: assert property (
		$rose(mspi_clk_out) && cfg_rate_in == 2'h0 |->
		(mspi_clk_out [*5] ##1 !mspi_clk_out) or ##[1:5] (user_io_enable_out || !config_reset_n_in))
		else $error("low rate half period");
	chk_mclk_high_rate: assert property (
		$rose(mspi_clk_out) && cfg_rate_in == 2'h2 |=> !mspi_clk_out || user_io_enable_out)
		else $error("high rate half period");
	chk_cs_master_only: assert property (
		!mspi_cs_n_out |-> cfg_source_in == 2'h1) else $error("flash selected off mode");
	chk_wr_hold: assert property (
		cfg_wr_valid_out && !cfg_wr_ready_in && config_reset_n_in |=>
		cfg_wr_valid_out && $stable(cfg_wr_data_out)) else $error("byte dropped");
	chk_req_pulse: assert property (
		otm_rd_req_out |=> !otm_rd_req_out) else $error("read request too long");
endmodule
bind cps_config_port_sequencer cps_monitor #(.CLEAR_CYCLES(CLEAR_CYCLES),
	.LOAD_LOW_CYCLES(LOAD_LOW_CYCLES), .LOAD_MED_CYCLES(LOAD_MED_CYCLES),
	.LOAD_HIGH_CYCLES(LOAD_HIGH_CYCLES)) mon (.clk_in, .sys_rst_in, .config_reset_n_in,
	.cfg_source_in, .cfg_rate_in, .config_done_flag_out, .user_io_enable_out,
	.config_error_out, .mspi_clk_out, .mspi_cs_n_out, .otm_rd_req_out, .cfg_wr_valid_out,
	.cfg_wr_data_out, .cfg_wr_ready_in);

// >>> bench/cps_flash_model.sv
// serial flash stand-in: takes the read command, streams bytes a0, a1, ...
`timescale 1ns/1ns
module cps_flash_model (
	// serial bus from the device
	input  wire logic   mclk_in,
	input  wire logic   cs_n_in,
	input  wire logic   mosi_in,
	output logic        miso_out = 1'b0,
	// captured command for the bench
	output logic [31:0] cmd_out = 32'h0
);
	int rises; // rising clocks within this select
	// command bits taken on rising clock, msb first
	always @(posedge mclk_in or posedge cs_n_in) begin
		if (cs_n_in) rises <= 0;
		else begin
			if (rises < 32) cmd_out <= {cmd_out[30:0], mosi_in};
			rises <= rises + 1;
		end
	end
	// data out on falling clock; released line shows inverse
	always @(negedge mclk_in or posedge cs_n_in) begin
		if (cs_n_in) miso_out <= ~miso_out;
		else if (rises >= 32) miso_out <= (8'ha0 + 8'((rises - 32) / 8)) >> (7 - (rises - 32) % 8);
	end
endmodule

// >>> bench/cps_config_port_sequencer_tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ns
module cps_config_port_sequencer_tb;
	import cps_pkg::*;
	logic       clk_in = 1'b0, sys_rst_in = 1'b1, config_reset_n_in = 1'b0;
	logic       sclk = 1'b0, sclk_on = 1'b1, stall = 1'b0; // link clock gate
	logic [1:0] cfg_source_in = 2'h0, cfg_rate_in = 2'h0;
	logic       slave_cs_n_in = 1'b1, slave_mosi_in = 1'b0, otm_rd_valid_in = 1'b0;
	logic       cfg_wr_ready_in = 1'b0, cfg_load_ok_in = 1'b0;
	logic [7:0] otm_rd_data_in = 8'h00, wd, rb;
	logic       done, io, err, mclk, mcs_n, mosi, fmiso, smiso, soe, req, wv;
	logic [15:0] addr;
	logic [31:0] cmd;
	logic [7:0] got[$]; // bytes taken by the array side
	int         num_errors = 0, n_compared = 0;
	always #4 clk_in = ~clk_in;
	// 15 ns link clock, still while the gate is off
	always begin #7; sclk = sclk_on; #8; sclk = 1'b0; end
	cps_config_port_sequencer #(.CLEAR_CYCLES(20), .LOAD_LOW_CYCLES(3000),
		.LOAD_MED_CYCLES(2000), .LOAD_HIGH_CYCLES(1500)) dut (.clk_in, .sys_rst_in,
		.config_reset_n_in, .cfg_source_in, .cfg_rate_in, .config_done_flag_out(done),
		.user_io_enable_out(io), .config_error_out(err), .mspi_clk_out(mclk),
		.mspi_cs_n_out(mcs_n), .mspi_mosi_out(mosi), .mspi_miso_in(fmiso),
		.slave_config_clock(sclk), .slave_cs_n_in, .slave_mosi_in, .slave_miso_out(smiso),
		.slave_miso_oe_out(soe), .otm_rd_req_out(req), .otm_rd_addr_out(addr),
		.otm_rd_valid_in, .otm_rd_data_in, .cfg_wr_valid_out(wv), .cfg_wr_data_out(wd),
		.cfg_wr_ready_in, .cfg_load_ok_in);
	cps_flash_model flash (.mclk_in(mclk), .cs_n_in(mcs_n), .mosi_in(mosi),
		.miso_out(fmiso), .cmd_out(cmd));
	////////////////////////////////////////////////////////////////////////////
	// memory answers next cycle; array ready every other cycle
	always @(posedge clk_in) begin
		otm_rd_valid_in <= req;
		otm_rd_data_in <= addr[7:0] ^ 8'h5a;
		cfg_wr_ready_in <= !stall && !cfg_wr_ready_in;
		if (wv && cfg_wr_ready_in) got.push_back(wd);
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// pin low 26 cycles; idle link clocks run on until its reset is out
	task automatic restart(input logic [1:0] src, input logic [1:0] rate);
		got.delete();
		@(posedge clk_in);
		cfg_source_in <= src;
		cfg_rate_in <= rate;
		config_reset_n_in <= 1'b0;
		sclk_on = 1'b1;
		repeat (26) @(posedge clk_in);
		config_reset_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		sclk_on = 1'b0;
	endtask
	// nb bytes, load ok, then done before io
	task automatic finish_load(input int nb);
		int n;
		for (n = 0; n < 3000 && got.size() < nb; n++) @(negedge clk_in);
		chk({31'h0, done}, 32'h0);
		@(posedge clk_in) cfg_load_ok_in <= 1'b1;
		@(posedge clk_in) cfg_load_ok_in <= 1'b0;
		for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk_in);
		chk({30'h0, done, io}, 32'h2);
		for (n = 0; n < 2000 && io !== 1'b1; n++) @(negedge clk_in);
		chk({30'h0, io, err}, 32'h2);
	endtask
	// slave frame of nr rises; rb gets readback
	task automatic sxfer(input logic [7:0] wb, input int nr);
		int i;
		@(posedge clk_in);
		slave_cs_n_in <= 1'b0;
		slave_mosi_in <= wb[7];
		@(posedge clk_in);
		sclk_on = 1'b1;
		for (i = 1; i <= nr; i++) begin
			@(posedge sclk) if (i > 1) rb[9 - i] = smiso;
			@(negedge sclk) if (i < 8) slave_mosi_in <= wb[7 - i];
		end
		sclk_on = 1'b0;
		slave_cs_n_in <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic test_otm; // high rate from internal memory
		restart(2'h0, 2'h2);
		finish_load(8);
		for (int k = 0; k < 8; k++) chk({24'h0, got[k]}, 32'(k) ^ 32'h5a);
		$display("test otm finished");
	endtask
	task automatic test_master; // low rate from flash
		restart(2'h1, 2'h0);
		finish_load(4);
		chk(cmd, 32'h03000000);
		for (int k = 0; k < 4; k++) chk({24'h0, got[k]}, 32'ha0 + 32'(k));
		$display("test master finished");
	endtask
	task automatic test_slave; // host writes, then reads status back
		restart(2'h2, 2'h3);
		repeat (28) @(posedge clk_in);
		sxfer(8'hc3, 8);
		sxfer(8'h3c, 8);
		sclk_on = 1'b1;
		finish_load(2);
		repeat (8) @(posedge clk_in); // let link side see io
		sclk_on = 1'b0;
		chk({got[0], got[1]}, 32'hc33c);
		sxfer(8'h00, 9);
		chk({23'h0, soe, rb}, 32'h1c0);
		$display("test slave finished");
	endtask
	task automatic test_fail; // array never ready: fifo fills, budget runs out
		int n;
		@(posedge clk_in) stall <= 1'b1;
		restart(2'h0, 2'h1);
		for (n = 0; n < 2300 && err !== 1'b1; n++) @(negedge clk_in);
		chk({30'h0, io, err}, 32'h1);
		@(posedge clk_in) stall <= 1'b0;
		$display("test fail finished");
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		test_otm();
		test_master();
		test_slave();
		test_fail();
		complete_run();
	end
	// tests need about 3600 cycles
	initial begin
		#400000;
		num_errors++;
		complete_run();
	end
endmodule
